// *** rtl/twsm_defines.vh ***
// Behaviour
// - direction bit 0 selects master-to-slave write, 1 selects slave-to-master read.
// - works at any serial clock rate up to 400kHz without speed setting.
// - every byte is followed by an acknowledge from its receiver.
// - first written data byte lands at the memory pointer byte.
// - slave drives data line in reads from address acknowledge, except master acknowledges.
// - master not-acknowledges the last byte; slave then releases the data line.
// - address register holds the 7-bit address in bits 7..1, default 1011001b.
// - pointer increments when the received byte's last bit arrives.
// - auto-incremented write bytes beyond 4Fh are discarded.
// - writes to read-only, reserved, locked or auto-incremented FEh locations are discarded.
// - partial bytes and unacknowledged bytes are never committed.
// - writes to unlocked EEPROM blocks change only the shadow copy.
// - read bytes go MSb first from the pointer, pointer increments after LSb.
// - reading past FFh returns FFh for every further byte.
// - reserved locations read as any value.
// - function command is a single-byte write to FEh; the byte at FFh is ignored, later bytes wrap to 00h and are written.
// - reading FEh returns a meaningless value.
// - idle slave watches for start plus matching address, acknowledges after direction.
// - new address takes effect immediately; becomes nonvolatile after block 1 copy.
// - multi-byte registers are stored most significant byte at the even address.
// - decode copy 42h/44h, recall B2h/B4h, lock 63h/66h, ROM identifier 39h.
`ifndef TWSM_DEFINES_VH
`define TWSM_DEFINES_VH

`define TWSM_DEVICE_SELECT_ADDRESS_LOC    8'h80
`define TWSM_DEVICE_SELECT_ADDRESS_RESET  8'hB2
`define TWSM_CMD_LOC      8'hFE
`define TWSM_AUTO_TOP     8'h4F
`define TWSM_READ_FILL    8'hFF
`define TWSM_CMD_READBACK 8'h00

`define TWSM_BLK0_LO      8'h20
`define TWSM_BLK0_HI      8'h2F
`define TWSM_BLK1_LO      8'h60
`define TWSM_BLK1_HI      8'h80

`define TWSM_OP_COPY0     8'h42
`define TWSM_OP_COPY1     8'h44
`define TWSM_OP_RECALL0   8'hB2
`define TWSM_OP_RECALL1   8'hB4
`define TWSM_OP_LOCK0     8'h63
`define TWSM_OP_LOCK1     8'h66
`define TWSM_OP_ROMID     8'h39

// identifier value is arbitrary
`define TWSM_ROM_ID       64'h0123456789ABCDEF

`define TWSM_FIFO_WIDTH   16
`define TWSM_FIFO_DEPTH   32
`define TWSM_FIFO_AW      5

`endif

// *** rtl/twsm_fifo.v ***
`timescale 1ns/1ns
`default_nettype none
module twsm_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             clk,       // system clock
   input  wire             resetn,    // synchronous reset, active low
   input  wire             in_valid,  // write side offers a word
   output wire             in_ready,  // space available
   input  wire [WIDTH-1:0] in_data,   // word to store
   output wire             out_valid, // a word is waiting
   input  wire             out_ready, // drain side takes the word
   output wire [WIDTH-1:0] out_data   // oldest word
);

   reg [WIDTH-1:0] store [0:DEPTH-1];
   reg [AW:0]      wr_ptr_reg;
   reg [AW:0]      rd_ptr_reg;
   wire            full;
   wire            empty;
   wire            do_push;
   wire            do_pop;

   assign empty     = (wr_ptr_reg == rd_ptr_reg);
   assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                      (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
   assign in_ready  = ~full;
   assign out_valid = ~empty;
   assign out_data  = store[rd_ptr_reg[AW-1:0]];
   assign do_push   = in_valid & ~full;
   assign do_pop    = out_ready & ~empty;

   always @(posedge clk) begin
      if (do_push) begin
         store[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (do_push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// *** rtl/twsm_slave.v ***
`include "twsm_defines.vh"
`timescale 1ns/1ns
`default_nettype none
module twsm_slave (
   input  wire clk,        // system clock, 100 MHz
   input  wire resetn,     // synchronous reset, active low
   input  wire scl_i,      // serial clock from the master
   input  wire sda_i,      // serial data line level
   input  wire lock_allow, // lock enable level for lock commands
   output reg  sda_o,      // serial data output value, always low
   output reg  sda_oe,     // high while pulling the data line low
   output reg  copy_busy   // shadow/nonvolatile transfer in progress
);

   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_ACK  = 3'd2;
   localparam ST_RX   = 3'd3;
   localparam ST_TX   = 3'd4;
   localparam ST_MACK = 3'd5;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function in_blk;
      input [7:0] a;
      input       b;
      begin
         if (b) begin
            in_blk = (a >= `TWSM_BLK1_LO) && (a <= `TWSM_BLK1_HI);
         end else begin
            in_blk = (a >= `TWSM_BLK0_LO) && (a <= `TWSM_BLK0_HI);
         end
      end
   endfunction

   // writable decision for one acknowledged data byte
   function wr_ok;
      input [7:0] a;
      input       first;
      input [1:0] lk;
      reg         reach;
      begin
         reach = 1'b0;
         if (first) begin
            reach = (a <= `TWSM_AUTO_TOP) || in_blk(a, 1'b1) || (a == `TWSM_CMD_LOC);
         end else begin
            reach = (a <= `TWSM_AUTO_TOP);
         end
         wr_ok = reach && !(in_blk(a, 1'b0) && lk[0]) &&
                 !(in_blk(a, 1'b1) && lk[1]);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and bus events

   reg scl_s1_reg;
   reg scl_s2_reg;
   reg scl_s3_reg;
   reg sda_s1_reg;
   reg sda_s2_reg;
   reg sda_s3_reg;

   always @(posedge clk) begin
      if (!resetn) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_s3_reg <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_s3_reg <= 1'b1;
      end else begin
         scl_s1_reg <= scl_i;
         scl_s2_reg <= scl_s1_reg;
         scl_s3_reg <= scl_s2_reg;
         sda_s1_reg <= sda_i;
         sda_s2_reg <= sda_s1_reg;
         sda_s3_reg <= sda_s2_reg;
      end
   end

   // edges found by oversampling, so no rate setting is needed
   wire scl_rise = scl_s2_reg & ~scl_s3_reg;
   wire scl_fall = ~scl_s2_reg & scl_s3_reg;
   wire scl_high = scl_s2_reg & scl_s3_reg;
   wire bus_start = scl_high & sda_s3_reg & ~sda_s2_reg;
   wire bus_stop  = scl_high & ~sda_s3_reg & sda_s2_reg;

   ////////////////////////////////////////////////////////////////////////////
   // memory map state

   reg  [7:0]  mem [0:255];
   reg  [7:0]  nv  [0:255];
   reg  [1:0]  lock_reg;
   reg         rom_mode_reg;
   reg         copy_dir_reg;
   reg         copy_blk_reg;
   reg  [7:0]  step_reg;
   reg         lock_s1_reg;
   reg         lock_s2_reg;

   wire [7:0]  dev_addr = mem[`TWSM_DEVICE_SELECT_ADDRESS_LOC];

   ////////////////////////////////////////////////////////////////////////////
   // serial engine state

   reg  [2:0]  state_reg;
   reg  [3:0]  bit_cnt_reg;
   reg  [7:0]  shift_reg;
   reg  [7:0]  ptr_reg;
   reg         ptr_ovf_reg;
   reg         dir_reg;
   reg         got_ptr_reg;
   reg         first_reg;
   reg  [7:0]  wr_addr_reg;
   reg  [2:0]  rom_idx_reg;
   reg         rom_clr_reg;
   reg         push_reg;
   reg  [15:0] push_data_reg;

   wire        fifo_in_ready;
   wire        fifo_out_valid;
   wire        fifo_out_ready;
   wire [15:0] fifo_out_data;

   // commits wait while a block transfer runs
   assign fifo_out_ready = ~copy_busy;

   twsm_fifo #(
      .WIDTH (`TWSM_FIFO_WIDTH),
      .DEPTH (`TWSM_FIFO_DEPTH),
      .AW    (`TWSM_FIFO_AW)
   ) u_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (push_reg),
      .in_ready  (fifo_in_ready),
      .in_data   (push_data_reg),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   // byte to send

   reg [7:0]  rd_byte;
   reg [63:0] rom_shift;

   always @* begin
      rom_shift = `TWSM_ROM_ID >> {rom_idx_reg, 3'b000};
      if (rom_mode_reg) begin
         rd_byte = rom_shift[7:0];
      end else if (ptr_ovf_reg) begin
         rd_byte = `TWSM_READ_FILL;
      end else if (ptr_reg == `TWSM_CMD_LOC) begin
         rd_byte = `TWSM_CMD_READBACK;
      end else begin
         rd_byte = mem[ptr_reg];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial engine

   always @(posedge clk) begin
      if (!resetn) begin
         state_reg     <= ST_IDLE;
         bit_cnt_reg   <= 4'h0;
         shift_reg     <= 8'h00;
         ptr_reg       <= 8'h00;
         ptr_ovf_reg   <= 1'b0;
         dir_reg       <= 1'b0;
         got_ptr_reg   <= 1'b0;
         first_reg     <= 1'b0;
         wr_addr_reg   <= 8'h00;
         rom_idx_reg   <= 3'h0;
         rom_clr_reg   <= 1'b0;
         push_reg      <= 1'b0;
         push_data_reg <= 16'h0000;
         sda_o         <= 1'b0;
         sda_oe        <= 1'b0;
      end else begin
         push_reg    <= 1'b0;
         rom_clr_reg <= 1'b0;
         if (bus_start) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe      <= 1'b0;
         end else if (bus_stop) begin
            state_reg <= ST_IDLE;
            sda_oe    <= 1'b0;
            if (dir_reg) begin
               rom_clr_reg <= 1'b1;
               rom_idx_reg <= 3'h0;
            end
         end else begin
            case (state_reg)
               ST_ADDR, ST_RX: begin
                  if (scl_rise && bit_cnt_reg < 4'h8) begin
                     shift_reg   <= {shift_reg[6:0], sda_s2_reg};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     if (state_reg == ST_RX && got_ptr_reg && bit_cnt_reg == 4'h7) begin
                        wr_addr_reg <= ptr_reg;
                        ptr_reg     <= ptr_reg + 8'h01;
                     end
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     bit_cnt_reg <= 4'h0;
                     if (state_reg == ST_ADDR) begin
                        if (shift_reg[7:1] == dev_addr[7:1]) begin
                           sda_oe      <= 1'b1;
                           dir_reg     <= shift_reg[0];
                           state_reg   <= ST_ACK;
                           if (!shift_reg[0]) begin
                              got_ptr_reg <= 1'b0;
                           end
                        end else begin
                           state_reg <= ST_IDLE;
                        end
                     end else if (!got_ptr_reg) begin
                        ptr_reg     <= shift_reg;
                        ptr_ovf_reg <= 1'b0;
                        got_ptr_reg <= 1'b1;
                        first_reg   <= 1'b1;
                        sda_oe      <= 1'b1;
                        state_reg   <= ST_ACK;
                     end else if (fifo_in_ready) begin
                        sda_oe    <= 1'b1;
                        state_reg <= ST_ACK;
                        first_reg <= 1'b0;
                        // only acknowledged whole bytes are queued
                        if (wr_ok(wr_addr_reg, first_reg, lock_reg)) begin
                           push_reg      <= 1'b1;
                           push_data_reg <= {wr_addr_reg, shift_reg};
                        end
                     end else begin
                        state_reg <= ST_IDLE;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     bit_cnt_reg <= 4'h0;
                     if (dir_reg) begin
                        shift_reg <= rd_byte;
                        sda_oe    <= ~rd_byte[7];
                        state_reg <= ST_TX;
                     end else begin
                        sda_oe    <= 1'b0;
                        state_reg <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_rise && bit_cnt_reg < 4'h8) begin
                     shift_reg   <= {shift_reg[6:0], 1'b1};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     if (bit_cnt_reg == 4'h7) begin
                        if (rom_mode_reg) begin
                           rom_idx_reg <= rom_idx_reg + 3'h1;
                        end else begin
                           if (ptr_reg == 8'hFF) begin
                              ptr_ovf_reg <= 1'b1;
                           end
                           ptr_reg <= ptr_reg + 8'h01;
                        end
                     end
                  end else if (scl_fall) begin
                     if (bit_cnt_reg == 4'h8) begin
                        bit_cnt_reg <= 4'h0;
                        sda_oe      <= 1'b0;
                        state_reg   <= ST_MACK;
                     end else begin
                        sda_oe <= ~shift_reg[7];
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise && sda_s2_reg) begin
                     state_reg <= ST_IDLE;
                  end else if (scl_fall) begin
                     shift_reg <= rd_byte;
                     sda_oe    <= ~rd_byte[7];
                     state_reg <= ST_TX;
                  end
               end
               default: begin
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // commit queue, commands and block transfers

   integer i;

   always @(posedge clk) begin
      if (!resetn) begin
         lock_s1_reg <= 1'b0;
         lock_s2_reg <= 1'b0;
      end else begin
         lock_s1_reg <= lock_allow;
         lock_s2_reg <= lock_s1_reg;
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         for (i = 0; i < 256; i = i + 1) begin
            mem[i] <= 8'h00;
            nv[i]  <= 8'h00;
         end
         mem[`TWSM_DEVICE_SELECT_ADDRESS_LOC] <= `TWSM_DEVICE_SELECT_ADDRESS_RESET;
         nv[`TWSM_DEVICE_SELECT_ADDRESS_LOC]  <= `TWSM_DEVICE_SELECT_ADDRESS_RESET;
         lock_reg     <= 2'b00;
         rom_mode_reg <= 1'b0;
         copy_dir_reg <= 1'b0;
         copy_blk_reg <= 1'b0;
         step_reg     <= 8'h00;
         copy_busy    <= 1'b0;
      end else begin
         if (rom_clr_reg) begin
            rom_mode_reg <= 1'b0;
         end
         if (copy_busy) begin
            if (copy_dir_reg) begin
               mem[step_reg] <= nv[step_reg];
            end else begin
               nv[step_reg] <= mem[step_reg];
            end
            if (step_reg == (copy_blk_reg ? `TWSM_BLK1_HI : `TWSM_BLK0_HI)) begin
               copy_busy <= 1'b0;
            end else begin
               step_reg <= step_reg + 8'h01;
            end
         end else if (fifo_out_valid) begin
            if (fifo_out_data[15:8] == `TWSM_CMD_LOC) begin
               case (fifo_out_data[7:0])
                  `TWSM_OP_COPY0, `TWSM_OP_COPY1: begin
                     // opcode bit 2 picks the block for copy as for recall
                     if (!lock_reg[fifo_out_data[2]]) begin
                        copy_busy    <= 1'b1;
                        copy_dir_reg <= 1'b0;
                        copy_blk_reg <= fifo_out_data[2];
                        step_reg     <= fifo_out_data[2] ? `TWSM_BLK1_LO : `TWSM_BLK0_LO;
                     end
                  end
                  `TWSM_OP_RECALL0, `TWSM_OP_RECALL1: begin
                     copy_busy    <= 1'b1;
                     copy_dir_reg <= 1'b1;
                     copy_blk_reg <= fifo_out_data[2];
                     step_reg     <= fifo_out_data[2] ? `TWSM_BLK1_LO : `TWSM_BLK0_LO;
                  end
                  `TWSM_OP_LOCK0: begin
                     if (lock_s2_reg) begin
                        lock_reg[0] <= 1'b1;
                     end
                  end
                  `TWSM_OP_LOCK1: begin
                     if (lock_s2_reg) begin
                        lock_reg[1] <= 1'b1;
                     end
                  end
                  `TWSM_OP_ROMID: begin
                     rom_mode_reg <= 1'b1;
                  end
                  default: begin
                     rom_mode_reg <= rom_mode_reg;
                  end
               endcase
            end else begin
               mem[fifo_out_data[15:8]] <= fifo_out_data[7:0];
            end
         end
      end
   end

endmodule
`default_nettype wire

// *** tb/twsm_slave_properties.sv ***
`timescale 1ns/1ns
`default_nettype none
module twsm_slave_props (
   input wire logic clk,        // system clock
   input wire logic resetn,     // synchronous reset, active low
   input wire logic scl_i,      // serial clock pin
   input wire logic sda_i,      // resolved data line
   input wire logic lock_allow, // lock enable level
   input wire logic sda_o,      // data output value
   input wire logic sda_oe,     // data pull-down enable
   input wire logic copy_busy   // block transfer running
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   a_data_low_only: assert property (!sda_o)
      else $error("data output value not low");
   a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !sda_oe && !copy_busy)
      else $error("outputs active after reset");
   a_oe_in_low: assert property ($changed(sda_oe) |-> !scl_i)
      else $error("data drive changed while clock high");
   a_oe_hold_high: assert property ($rose(scl_i) |=> $stable(sda_oe) [*4])
      else $error("data drive moved in clock high phase");
   a_ack_full_bit: assert property ($rose(sda_oe) |-> sda_oe [*8])
      else $error("driven bit shorter than a clock");
   a_busy_length: assert property ($rose(copy_busy) |-> ##15 copy_busy ##1
      (!copy_busy or ##16 copy_busy ##1 !copy_busy))
      else $error("block transfer length wrong");
   a_busy_in_ack: assert property ($rose(copy_busy) |-> sda_oe)
      else $error("transfer started outside a data acknowledge");
   a_stop_release: assert property (scl_i && $rose(sda_i) |-> !sda_oe [*8])
      else $error("data line driven after stop");
endmodule
`default_nettype wire

// *** tb/twsm_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module twsm_host (
   input  wire logic clk,  // system clock
   input  wire logic sda,  // resolved data line
   output var  logic scl,  // serial clock, high between frames
   output var  logic m_oe  // high while pulling data low
);
   initial begin
      scl = 1'b1;
      m_oe = 1'b0;
   end
   task tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one 160 ns clock: data set in the low half, sampled mid-high
   task bit_io(input logic b, output logic r);
      m_oe <= ~b;
      tk(4);
      scl <= 1'b1;
      tk(4);
      r = sda;
      tk(4);
      scl <= 1'b0;
      tk(4);
   endtask
   // serves as start and as repeated start
   task start;
      m_oe <= 1'b0;
      tk(4);
      scl <= 1'b1;
      tk(4);
      m_oe <= 1'b1;
      tk(4);
      scl <= 1'b0;
      tk(4);
   endtask
   task stop;
      m_oe <= 1'b1;
      tk(4);
      scl <= 1'b1;
      tk(4);
      m_oe <= 1'b0;
      tk(4);
   endtask
   task wbyte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = (r === 1'b0);
   endtask
   task rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule
`default_nettype wire

// *** tb/two_wire_slave_memory_protocol_tb.sv ***
`timescale 1ns/1ns
`include "twsm_defines.vh"
`default_nettype none
module two_wire_slave_memory_protocol_tb;
   logic        clk, resetn, lock_allow, sda_o, sda_oe, copy_busy, scl, m_oe, sda;
   logic [7:0]  sh [0:255];
   logic [7:0]  nv [0:255];
   logic [7:0]  wb [0:7];
   logic [7:0]  ops [0:7];
   logic [63:0] rid;
   logic [6:0]  dev;
   logic        lk0, lk1, rom;
   int          mismatches, comparisons, cyc;
   assign sda = ~(m_oe | sda_oe);
   twsm_host host (.clk(clk), .sda(sda), .scl(scl), .m_oe(m_oe));
   twsm_slave dut (.clk(clk), .resetn(resetn), .scl_i(scl), .sda_i(sda),
      .lock_allow(lock_allow), .sda_o(sda_o), .sda_oe(sda_oe), .copy_busy(copy_busy));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         mismatches++;
         $display("CHECK FAILED %0t run too long", $time);
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task chk(input logic c, input string m);
      comparisons++;
      if (c !== 1'b1) begin
         mismatches++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic bit in0(int p);
      return p >= `TWSM_BLK0_LO && p <= `TWSM_BLK0_HI;
   endfunction
   function automatic bit in1(int p);
      return p >= `TWSM_BLK1_LO && p <= `TWSM_BLK1_HI;
   endfunction
   function automatic bit ok(int p, bit first);
      if ((lk0 && in0(p)) || (lk1 && in1(p))) return 1'b0;
      return p <= `TWSM_AUTO_TOP || (first && (in1(p) || p == `TWSM_CMD_LOC));
   endfunction
   function automatic bit known(int p);
      return p > 255 || p <= `TWSM_AUTO_TOP || in1(p) || p == `TWSM_CMD_LOC;
   endfunction
   function automatic logic [7:0] ex(int p);
      if (p > 255) return `TWSM_READ_FILL;
      if (p == `TWSM_CMD_LOC) return `TWSM_CMD_READBACK;
      return sh[p];
   endfunction
   task cmd(input logic [7:0] c);
      for (int i = 0; i < 256; i++) begin
         if (in0(i) && c == `TWSM_OP_COPY0 && !lk0) nv[i] = sh[i];
         if (in1(i) && c == `TWSM_OP_COPY1 && !lk1) nv[i] = sh[i];
         if (in0(i) && c == `TWSM_OP_RECALL0) sh[i] = nv[i];
         if (in1(i) && c == `TWSM_OP_RECALL1) sh[i] = nv[i];
      end
      if (c == `TWSM_OP_LOCK0 && lock_allow) lk0 = 1'b1;
      if (c == `TWSM_OP_LOCK1 && lock_allow) lk1 = 1'b1;
      if (c == `TWSM_OP_ROMID) rom = 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task wr(input logic [7:0] p, input int n);
      logic a;
      host.start();
      host.wbyte({dev, 1'b0}, a);
      chk(a, "address not acknowledged");
      host.wbyte(p, a);
      chk(a, "pointer not acknowledged");
      for (int i = 0; i < n; i++) begin
         host.wbyte(wb[i], a);
         chk(a, "data not acknowledged");
         if (ok(p + i, i == 0)) begin
            if (p + i == `TWSM_CMD_LOC) cmd(wb[i]);
            else sh[p + i] = wb[i];
         end
      end
      host.stop();
      dev = sh[`TWSM_DEVICE_SELECT_ADDRESS_LOC][7:1];
      host.tk(60);
   endtask
   task rd(input logic [7:0] p, input int n);
      logic       a;
      logic [7:0] d;
      host.start();
      if (!rom) begin
         host.wbyte({dev, 1'b0}, a);
         host.wbyte(p, a);
         host.start();
      end
      host.wbyte({dev, 1'b1}, a);
      chk(a, "read address not acknowledged");
      for (int i = 0; i < n; i++) begin
         host.rbyte(i == n - 1, d);
         if (rom) chk(d === rid[8*(i%8) +: 8], "identifier byte wrong");
         else if (known(p + i)) chk(d === ex(p + i), "read byte wrong");
      end
      host.stop();
      rom = 1'b0;
      host.tk(20);
   endtask
   task probe(input logic [6:0] ad, input logic e);
      logic a;
      host.start();
      host.wbyte({ad, 1'b0}, a);
      host.stop();
      chk(a === e, "presence answer wrong");
      host.tk(20);
   endtask
   task rnd;
      for (int i = 0; i < 8; i++) wb[i] = 8'($urandom);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      resetn = 1'b0;
      lock_allow = 1'b0;
      for (int i = 0; i < 256; i++) sh[i] = 8'h00;
      for (int i = 0; i < 256; i++) nv[i] = 8'h00;
      sh[`TWSM_DEVICE_SELECT_ADDRESS_LOC] = `TWSM_DEVICE_SELECT_ADDRESS_RESET;
      nv[`TWSM_DEVICE_SELECT_ADDRESS_LOC] = `TWSM_DEVICE_SELECT_ADDRESS_RESET;
      dev = 7'h59;
      {lk0, lk1, rom} = 3'b000;
      rid = `TWSM_ROM_ID;
      ops = '{8'h42, 8'h5A, 8'hB2, 8'h63, 8'h39, 8'h44, 8'hB4, 8'h66};
      void'($urandom(51903));
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      host.tk(8);
      probe(dev, 1'b1);
      probe(dev ^ 7'h01, 1'b0);
      rd(`TWSM_DEVICE_SELECT_ADDRESS_LOC, 1);
      rnd();
      wr(8'h4E, 4);
      wb[1] = `TWSM_OP_ROMID;
      wr(8'hFD, 2);
      rnd();
      wr(8'h7F, 2);
      rd(8'h4C, 6);
      wb[0] = 8'hA4;
      wr(`TWSM_DEVICE_SELECT_ADDRESS_LOC, 1);
      probe(7'h59, 1'b0);
      probe(dev, 1'b1);
      for (int k = 0; k < 8; k++) begin
         rnd();
         wr(8'($urandom_range(0, 8'h7F)), $urandom_range(1, 4));
         lock_allow <= 1'($urandom_range(0, 1));
         host.tk(1);
         wb[0] = ops[k];
         wr(`TWSM_CMD_LOC, 2);
         rd(8'($urandom_range(0, 8'h80)), 4);
      end
      rd(8'hFC, 6);
      for (int k = 0; k < 14; k++) begin
         rnd();
         wr(8'($urandom_range(0, 8'h7F)), $urandom_range(1, 4));
         rd(8'($urandom_range(0, 255)), $urandom_range(1, 6));
      end
      end_of_test();
   end
endmodule
bind twsm_slave twsm_slave_props props (.clk(clk), .resetn(resetn), .scl_i(scl_i),
   .sda_i(sda_i), .lock_allow(lock_allow), .sda_o(sda_o), .sda_oe(sda_oe),
   .copy_busy(copy_busy));
`default_nettype wire
